// [design/slacc_defs.vh]
`ifndef SLACC_DEFS_VH
`define SLACC_DEFS_VH

// Register offsets
`define SLACC_VEL_CFG_ADDR 8'h3e
`define SLACC_RECAL_ADDR 8'h3f
`define SLACC_UNMAPPED_DATA 8'h00

// Reset values
`define SLACC_VEL_CFG_RST 8'hc5
`define SLACC_RECAL_RST 8'h00

// Velocity config field positions
`define SLACC_ACC_EN_BIT 7
`define SLACC_MAX_INT_HI 6
`define SLACC_MAX_INT_LO 4
`define SLACC_SLIDE_TIME_HI 3
`define SLACC_SLIDE_TIME_LO 2
`define SLACC_SCALE_HI 1
`define SLACC_SCALE_LO 0

// Recalibration bit positions
`define SLACC_GROUP_RECAL_BIT 7

// Timing, in milliseconds as printed
`define SLACC_MEAS_CYCLE_MS 35
`define SLACC_SPEED_WIN_MS 100
`define SLACC_SLIDE_T0_MS 350
`define SLACC_SLIDE_T1_MS 560
`define SLACC_SLIDE_T2_MS 770
`define SLACC_SLIDE_T3_MS 980
`define SLACC_RPT_35_MS 35
`define SLACC_RPT_70_MS 70
`define SLACC_RPT_105_MS 105
`define SLACC_RPT_140_MS 140

// Timing, in measurement cycles (all times round down, only 100 ms is inexact, never below one)
`define SLACC_TICKS(ms) ((ms) / `SLACC_MEAS_CYCLE_MS)
`define SLACC_SPEED_WIN_TICKS `SLACC_TICKS(`SLACC_SPEED_WIN_MS)

`endif

// [design/slacc_recal_bit.v]
`default_nettype none

module slacc_recal_bit (
	input wire core_clk_in,
	input wire reset_in,
	input wire ce_in,
	input wire set_in,
	input wire done_in,
	output reg req_out,
	output reg start_out
);

	always @(posedge core_clk_in)
	begin
		if (reset_in)
		begin
			req_out <= 1'b0;
			start_out <= 1'b0;
		end
		else if (ce_in)
		begin
			// A request landing on completion is kept and starts a new routine
			start_out <= set_in & (~req_out | done_in);
			if (set_in)
				req_out <= 1'b1;
			else if (done_in)
				req_out <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// [design/slacc_top.v]
// How it works
// - Enable set: extra interrupts after fast slide
// - Enable clear: never any extra interrupts
// - Cap field limits extra interrupts per slide
// - Count shrinks with slide time fraction
// - Slides beyond slide-time setting earn nothing
// - Slide-time codes give 350/560/770/980 ms
// - Speed is sensors touched per 2-cycle window (100 ms rounded down)
// - Scale table picks repeat interval
// - Fast base rate: code 11 fixed intervals
// - Interval counted in measurement cycles
// - Recal bit forces channel base recalibration
// - Recal bit self-clears when routine ends
// - Bit 7 group, bits 6..0 channels 7..1
// - Grouped sensors act as one slider
`include "slacc_defs.vh"
`default_nettype none

module slacc_top #(
	parameter GROUP_SENSORS = 7,
	parameter TCNT_W = 6
) (
	input wire core_clk_in,
	input wire reset_in,
	input wire ce_in,
	input wire [7:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	output reg [7:0] reg_rdata_out,
	input wire meas_tick_in,
	input wire [GROUP_SENSORS-1:0] group_touch_in,
	input wire [3:0] slider_base_repeat_interval_in,
	input wire [7:0] recal_done_in,
	output wire [7:0] recal_req_out,
	output wire [7:0] recal_start_out,
	output reg extra_irq_out
);

	localparam ST_IDLE = 2'd0;
	localparam ST_SLIDE = 2'd1;
	localparam ST_BURST = 2'd2;
	localparam [TCNT_W-1:0] T_MAX = {TCNT_W{1'b1}};
	localparam integer WIN_I = `SLACC_SPEED_WIN_TICKS;
	localparam integer SL0_I = `SLACC_TICKS(`SLACC_SLIDE_T0_MS);
	localparam integer SL1_I = `SLACC_TICKS(`SLACC_SLIDE_T1_MS);
	localparam integer SL2_I = `SLACC_TICKS(`SLACC_SLIDE_T2_MS);
	localparam integer SL3_I = `SLACC_TICKS(`SLACC_SLIDE_T3_MS);
	localparam integer RP35_I = `SLACC_TICKS(`SLACC_RPT_35_MS);
	localparam integer RP70_I = `SLACC_TICKS(`SLACC_RPT_70_MS);
	localparam integer RP105_I = `SLACC_TICKS(`SLACC_RPT_105_MS);
	localparam integer RP140_I = `SLACC_TICKS(`SLACC_RPT_140_MS);
	localparam [3:0] WIN_TICKS = WIN_I[3:0];

	reg [7:0] vel_cfg_q;
	reg [1:0] state_q;
	reg [GROUP_SENSORS-1:0] prev_touch_q;
	reg [TCNT_W-1:0] t_cnt_q;
	reg [TCNT_W-1:0] last_t_q;
	reg [3:0] win_timer_q;
	reg [2:0] win_cnt_q;
	reg [2:0] speed_q;
	reg [2:0] remain_q;
	reg [3:0] gap_q;
	reg [3:0] wait_q;

	wire accel_extra_irq_enable = vel_cfg_q[`SLACC_ACC_EN_BIT];
	wire [2:0] max_int = vel_cfg_q[`SLACC_MAX_INT_HI:`SLACC_MAX_INT_LO];
	wire [1:0] slide_time_code = vel_cfg_q[`SLACC_SLIDE_TIME_HI:`SLACC_SLIDE_TIME_LO];
	wire [1:0] repeat_speed_scale = vel_cfg_q[`SLACC_SCALE_HI:`SLACC_SCALE_LO];

	wire reg_sel_cfg = reg_addr_in == `SLACC_VEL_CFG_ADDR;
	wire reg_sel_recal = reg_addr_in == `SLACC_RECAL_ADDR;
	wire [GROUP_SENSORS-1:0] new_touch = group_touch_in & ~prev_touch_q;
	wire any_touch = |group_touch_in;

	function [2:0] popcount;
		input [GROUP_SENSORS-1:0] v;
		integer i;
		reg [3:0] acc;
		begin
			acc = 4'd0;
			for (i = 0; i < GROUP_SENSORS; i = i + 1)
				acc = acc + {3'd0, v[i]};
			popcount = (acc > 4'd7) ? 3'd7 : acc[2:0];
		end
	endfunction

	// Sum kept one bit wider so the saturation sees the carry
	wire [3:0] win_sum = {1'b0, win_cnt_q} + {1'b0, popcount(new_touch)};
	wire [2:0] win_sat = win_sum[3] ? 3'd7 : win_sum[2:0];

	// Slide-time setting in measurement cycles
	reg [TCNT_W-1:0] slide_ticks;
	always @*
	begin
		case (slide_time_code)
			2'b00: slide_ticks = SL0_I[TCNT_W-1:0];
			2'b01: slide_ticks = SL1_I[TCNT_W-1:0];
			2'b10: slide_ticks = SL2_I[TCNT_W-1:0];
			default: slide_ticks = SL3_I[TCNT_W-1:0];
		endcase
	end

	// Extra interrupt count from slide time against the setting
	wire [TCNT_W+2:0] t_x4 = {1'b0, last_t_q, 2'b00};
	wire [TCNT_W+2:0] s_x2 = {2'b00, slide_ticks, 1'b0};
	wire [TCNT_W+2:0] s_x3 = {3'b000, slide_ticks} + {2'b00, slide_ticks, 1'b0};
	reg [2:0] burst_count;
	always @*
	begin
		if (last_t_q > slide_ticks)
			burst_count = 3'd0;
		else if (t_x4 < s_x2)
			burst_count = max_int;
		else if (t_x4 < s_x3)
			burst_count = {1'b0, max_int[2:1]};
		else
			burst_count = {2'b00, max_int[2]};
	end

	// Repeat interval in measurement cycles from speed and scale
	reg [3:0] interval;
	always @*
	begin
		interval = RP35_I[3:0];
		if (speed_q >= 3'd5)
			interval = RP35_I[3:0];
		else if (repeat_speed_scale == 2'b11 && speed_q >= 3'd2)
		begin
			// Code 11 uses the fixed table row values for speeds 2 to 4
			case (speed_q)
				3'd4: interval = RP70_I[3:0];
				3'd3: interval = RP105_I[3:0];
				default: interval = RP140_I[3:0];
			endcase
		end
		else
		begin
			case (speed_q)
				3'd4: interval = RP35_I[3:0];
				3'd3: interval = repeat_speed_scale[1] ? RP70_I[3:0] : RP35_I[3:0];
				3'd2:
				begin
					if (repeat_speed_scale == 2'b00)
						interval = RP35_I[3:0];
					else if (repeat_speed_scale == 2'b01)
						interval = RP70_I[3:0];
					else
						interval = RP105_I[3:0];
				end
				default: interval = slider_base_repeat_interval_in;
			endcase
		end
		// A zero base interval is raised to one; the burst counter fires every tick for either
		if (interval == 4'd0)
			interval = 4'd1;
	end

	// Register port
	always @(posedge core_clk_in)
	begin
		if (reset_in)
		begin
			vel_cfg_q <= `SLACC_VEL_CFG_RST;
			reg_rdata_out <= `SLACC_UNMAPPED_DATA;
		end
		else if (ce_in)
		begin
			if (reg_wr_in && reg_sel_cfg)
				vel_cfg_q <= reg_wdata_in;
			if (reg_rd_in)
			begin
				if (reg_sel_cfg)
					reg_rdata_out <= vel_cfg_q;
				else if (reg_sel_recal)
					reg_rdata_out <= recal_req_out;
				else
					reg_rdata_out <= `SLACC_UNMAPPED_DATA;
			end
		end
	end

	// Recalibration requests; bit 7 is the whole group, 6..0 are channels 7..1
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1)
		begin : recal
			slacc_recal_bit u_bit (
				.core_clk_in(core_clk_in),
				.reset_in(reset_in),
				.ce_in(ce_in),
				.set_in(reg_wr_in & reg_sel_recal & reg_wdata_in[g]),
				.done_in(recal_done_in[g]),
				.req_out(recal_req_out[g]),
				.start_out(recal_start_out[g])
			);
		end
	endgenerate

	// Slide tracking and extra interrupt burst
	always @(posedge core_clk_in)
	begin
		if (reset_in)
		begin
			state_q <= ST_IDLE;
			prev_touch_q <= {GROUP_SENSORS{1'b0}};
			t_cnt_q <= {TCNT_W{1'b0}};
			last_t_q <= {TCNT_W{1'b0}};
			win_timer_q <= 4'd0;
			win_cnt_q <= 3'd0;
			speed_q <= 3'd0;
			remain_q <= 3'd0;
			gap_q <= 4'd0;
			wait_q <= 4'd0;
			extra_irq_out <= 1'b0;
		end
		else if (ce_in)
		begin
			extra_irq_out <= 1'b0;
			if (meas_tick_in)
			begin
				// Grouped sensors are sampled together as one slider
				prev_touch_q <= group_touch_in;
				case (state_q)
					ST_IDLE, ST_BURST:
					begin
						if (|new_touch)
						begin
							// A new touch restarts slide timing and drops any burst
							state_q <= ST_SLIDE;
							t_cnt_q <= {TCNT_W{1'b0}};
							last_t_q <= {TCNT_W{1'b0}};
							win_timer_q <= 4'd1;
							win_cnt_q <= popcount(new_touch);
							speed_q <= popcount(new_touch);
						end
						else if (state_q == ST_BURST)
						begin
							if (!accel_extra_irq_enable)
								state_q <= ST_IDLE;
							else if (wait_q <= 4'd1)
							begin
								extra_irq_out <= 1'b1;
								wait_q <= gap_q;
								remain_q <= remain_q - 3'd1;
								if (remain_q == 3'd1)
									state_q <= ST_IDLE;
							end
							else
								wait_q <= wait_q - 4'd1;
						end
					end
					ST_SLIDE:
					begin
						if (t_cnt_q != T_MAX)
							t_cnt_q <= t_cnt_q + {{(TCNT_W-1){1'b0}}, 1'b1};
						if (|new_touch)
							last_t_q <= t_cnt_q + {{(TCNT_W-1){1'b0}}, 1'b1};
						// Peak count of sensors touched in any speed window
						if (win_timer_q >= WIN_TICKS)
						begin
							win_timer_q <= 4'd1;
							win_cnt_q <= popcount(new_touch);
						end
						else
						begin
							win_timer_q <= win_timer_q + 4'd1;
							win_cnt_q <= win_sat;
							if (win_sat > speed_q)
								speed_q <= win_sat;
						end
						if (!any_touch)
						begin
							if (accel_extra_irq_enable && burst_count != 3'd0)
							begin
								state_q <= ST_BURST;
								remain_q <= burst_count;
								gap_q <= interval;
								wait_q <= interval;
							end
							else
								state_q <= ST_IDLE;
						end
					end
					default: state_q <= ST_IDLE;
				endcase
			end
		end
	end

endmodule

`default_nettype wire

// [dv/slacc_top_monitor.sv]
`default_nettype none
module slacc_top_monitor #(
	parameter GROUP_SENSORS = 7
) (
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic meas_tick_in,
	input wire logic [GROUP_SENSORS-1:0] group_touch_in,
	input wire logic [7:0] recal_done_in,
	input wire logic [7:0] recal_req_out,
	input wire logic [7:0] recal_start_out,
	input wire logic extra_irq_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cfg_q;
	logic [2:0] burst_q;
	wire cal_wr = reg_wr_in && reg_addr_in == 8'h3f;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (reset_in);
	// Shadow of the config and irqs since the last touch tick
	always_ff @(posedge core_clk_in)
	begin
		if (reset_in)
		begin
			cfg_q <= 8'hc5;
			burst_q <= 3'h0;
		end
		else
		begin
			if (reg_wr_in && reg_addr_in == 8'h3e)
				cfg_q <= reg_wdata_in;
			if (meas_tick_in && |group_touch_in)
				burst_q <= 3'h0;
			else if (extra_irq_out && burst_q != 3'h7)
				burst_q <= burst_q + 3'h1;
		end
	end
	irq_on_tick_a: assert property (extra_irq_out |-> $past(meas_tick_in))
		else $error("extra irq not after a tick");
	irq_disabled_a: assert property (!cfg_q[7] && !$past(cfg_q[7]) |-> !extra_irq_out)
		else $error("extra irq while disabled");
	burst_cap_a: assert property (extra_irq_out |-> burst_q < cfg_q[6:4])
		else $error("extra irq beyond cap");
	cfg_read_a: assert property (reg_rd_in && !reg_wr_in && reg_addr_in == 8'h3e
		|=> reg_rdata_out == $past(cfg_q))
		else $error("config read mismatch");
	unmapped_read_a: assert property (reg_rd_in && reg_addr_in[7:1] != 7'h1f
		|=> reg_rdata_out == 8'h00)
		else $error("unmapped read not zero");
	recal_set_a: assert property (cal_wr
		|=> (recal_req_out & $past(reg_wdata_in)) == $past(reg_wdata_in))
		else $error("recal request not set");
	recal_start_a: assert property (recal_start_out != 8'h00
		|-> (recal_start_out & $past(recal_req_out) & ~$past(recal_done_in)) == 8'h00)
		else $error("start on a pending bit");
	recal_clear_a: assert property (!cal_wr && (recal_done_in & recal_req_out) != 8'h00
		|=> (recal_req_out & $past(recal_done_in)) == 8'h00)
		else $error("recal request not cleared");
	cover property (extra_irq_out);
	cover property (recal_start_out[7]);
	cover property (!cfg_q[7] && meas_tick_in);
endmodule
bind slacc_top slacc_top_monitor #(.GROUP_SENSORS(GROUP_SENSORS)) i_mon (
	.core_clk_in(core_clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out), .meas_tick_in(meas_tick_in),
	.group_touch_in(group_touch_in), .recal_done_in(recal_done_in),
	.recal_req_out(recal_req_out), .recal_start_out(recal_start_out),
	.extra_irq_out(extra_irq_out));
`default_nettype wire

// [dv/slacc_engine_model.sv]
`default_nettype none
module slacc_engine_model (
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic [7:0] dly_in,
	input wire logic [7:0] recal_start_in,
	output logic [7:0] recal_done_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] pend_q;
	logic [7:0] cnt_q;
	// A new start restarts the shared delay, so bits started together finish together
	always_ff @(posedge core_clk_in)
	begin
		recal_done_out <= 8'h00;
		if (reset_in)
		begin
			pend_q <= 8'h00;
			cnt_q <= 8'h00;
		end
		else if (recal_start_in != 8'h00)
		begin
			pend_q <= pend_q | recal_start_in;
			cnt_q <= dly_in;
		end
		else if (cnt_q != 8'h00)
		begin
			cnt_q <= cnt_q - 8'h01;
			if (cnt_q == 8'h01)
			begin
				recal_done_out <= pend_q;
				pend_q <= 8'h00;
			end
		end
	end
endmodule
`default_nettype wire

// [dv/tb_slacc_top.sv]
`default_nettype none
module tb_slacc_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic tick = 1'b0;
	logic [1:0] div = 2'h0;
	logic [6:0] touch = 7'h00;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] dly = 8'h14;
	logic [3:0] base = 4'h3;
	wire [7:0] rdata;
	wire [7:0] done;
	wire [7:0] req;
	wire [7:0] start;
	wire irq;
	int fails = 0;
	int checks = 0;
	int tick_n = 0;
	int irq_n = 0;
	int mark = 0;
	int first = 0;
	int last = 0;
	int rel = 0;
	slacc_top i_slacc_top (.core_clk_in(clk), .reset_in(rst), .ce_in(1'b1),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdata), .meas_tick_in(tick), .group_touch_in(touch),
		.slider_base_repeat_interval_in(base), .recal_done_in(done),
		.recal_req_out(req), .recal_start_out(start), .extra_irq_out(irq));
	slacc_engine_model i_slacc_engine_model (.core_clk_in(clk), .reset_in(rst),
		.dly_in(dly), .recal_start_in(start), .recal_done_out(done));
	always #10 clk = ~clk;
	// Measurement tick every fourth clock keeps the slide runs short
	always @(posedge clk)
	begin
		div <= div + 2'h1;
		tick <= div == 2'h3;
		if (tick)
			tick_n <= tick_n + 1;
		if (irq)
		begin
			if (irq_n == mark)
				first <= tick_n;
			last <= tick_n;
			irq_n <= irq_n + 1;
		end
	end
	task stop_test;
		if (fails == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
	endtask
	task rdc(input logic [7:0] a, input logic [7:0] exp);
		acc(1'b0, a, 8'h00);
		chk(rdata, exp);
	endtask
	task wt;
		int i;
		i = 0;
		do
		begin
			@(posedge clk);
			i++;
		end
		while (!tick && i < 8);
		if (!tick)
		begin
			fails++;
			stop_test;
		end
	endtask
	task poll;
		int i;
		i = 0;
		do
		begin
			acc(1'b0, 8'h3f, 8'h00);
			i++;
		end
		while (rdata !== 8'h00 && i < 40);
		chk(rdata, 8'h00);
	endtask
	// Sensor patterns touched one step after another, gap ticks apart, then all released
	task slide(input logic [7:0] cfg, input logic [6:0] pat, input int n, input int gap,
		input int cnt, input int ivl);
		acc(1'b1, 8'h3e, cfg);
		mark = irq_n;
		wt;
		for (int k = 0; k < n; k++)
		begin
			touch <= pat << k;
			repeat (gap) wt;
		end
		touch <= 7'h00;
		rel = tick_n;
		repeat (40) wt;
		chk(8'(irq_n - mark), 8'(cnt));
		if (cnt > 0)
		begin
			chk(8'(first - rel), 8'(ivl + 2));
			chk(8'(last - first), 8'((cnt - 1) * ivl));
		end
	endtask
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rdc(8'h3e, 8'hc5);
		rdc(8'h3f, 8'h00);
		rdc(8'h40, 8'h00);
		slide(8'hc5, 7'h01, 3, 1, 4, 2);
		slide(8'h45, 7'h01, 3, 1, 0, 2);
		slide(8'hb5, 7'h01, 3, 1, 3, 2);
		slide(8'hc7, 7'h01, 3, 1, 4, 4);
		slide(8'hc5, 7'h01, 2, 9, 2, 3);
		slide(8'hc5, 7'h01, 2, 14, 1, 3);
		slide(8'hc5, 7'h01, 2, 17, 0, 3);
		slide(8'hc1, 7'h01, 2, 9, 1, 3);
		slide(8'hcd, 7'h01, 2, 20, 2, 3);
		slide(8'hc6, 7'h07, 1, 1, 4, 2);
		slide(8'hc4, 7'h0f, 1, 1, 4, 1);
		slide(8'hc7, 7'h0f, 1, 1, 4, 2);
		slide(8'hc7, 7'h1f, 1, 1, 4, 1);
		base <= 4'h5;
		slide(8'hc5, 7'h01, 2, 9, 2, 5);
		rdc(8'h3e, 8'hc5);
		acc(1'b1, 8'h3f, 8'hff);
		rdc(8'h3f, 8'hff);
		poll;
		acc(1'b1, 8'h3f, 8'h01);
		acc(1'b1, 8'h3f, 8'h00);
		rdc(8'h3f, 8'h01);
		poll;
		dly <= 8'h01;
		acc(1'b1, 8'h3f, 8'h81);
		poll;
		stop_test;
	end
endmodule
`default_nettype wire
